// ==== hw/bvr_bank.sv ====
// buck voltage register bank: two converter control registers
// Contract
// - buck1 skip enable resets 1; 0 forces PWM
// - buck1 six-bit code resets zero, read-write
// - buck2 register at 0x17, reset 0x99
// - buck1/buck2 writes without unlock are ignored; the apply write needs no unlock
// - buck2 write blanks OV/UV monitoring 5 ms
// - new code applies only after apply bit set
// - buck2 bit 7 skip enable, resets 1
// - buck1 register at 0x16, reset 0x80
// - buck1 write blanks OV/UV monitoring 5 ms
// - buck1 code applies on apply; password protected
`timescale 1ns/10ps
`default_nettype none
module bvr_bank #(
  parameter int BLANK_CYCLES = bvr_pkg::BVR_BLANK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic unlocked,
  output logic [7:0] reg_rdata,
  output logic buck1_skip_en,
  output logic [bvr_pkg::BVR_CODE_W-1:0] buck1_code_out,
  output logic buck2_skip_en,
  output logic [bvr_pkg::BVR_CODE_W-1:0] buck2_code_out,
  output logic buck1_mon_blank,
  output logic buck2_mon_blank
);
  import bvr_pkg::*;

  initial begin
    if (BLANK_CYCLES < 1) $error("bvr_bank: BLANK_CYCLES must be >= 1");
  end

  logic [7:0] buck1_ff;
  logic [7:0] buck2_ff;
  logic [7:0] rdata_ff;
  logic [BVR_CODE_W-1:0] code1_ff;
  logic [BVR_CODE_W-1:0] code2_ff;
  logic skip1_ff;
  logic skip2_ff;
  logic blank1_ff;
  logic blank2_ff;
  logic wr1;
  logic wr2;
  logic apply;
  logic blank1;
  logic blank2;

  // a locked write never reaches storage nor starts blanking
  assign wr1 = reg_wr && unlocked && reg_addr == BVR_ADDR_BUCK1;
  assign wr2 = reg_wr && unlocked && reg_addr == BVR_ADDR_BUCK2;
  assign apply = reg_wr && reg_addr == BVR_ADDR_APPLY
    && (reg_wdata[BVR_APPLY_BIT] || reg_wdata[BVR_APPLY_ALT_BIT]);

  // reserved bit masked out on every write store; the buck1 reset load is not masked
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      buck1_ff <= BVR_RST_BUCK1;
    end else if (wr1) begin
      buck1_ff <= reg_wdata & BVR_RMASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      buck2_ff <= BVR_RST_BUCK2 & BVR_RMASK;
    end else if (wr2) begin
      buck2_ff <= reg_wdata & BVR_RMASK;
    end
  end

  // skip-enable follows the stored bit one cycle later; only the voltage code waits for apply
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      skip1_ff <= BVR_RST_BUCK1[BVR_SKIP_BIT];
      skip2_ff <= BVR_RST_BUCK2[BVR_SKIP_BIT];
    end else begin
      skip1_ff <= buck1_ff[BVR_SKIP_BIT];
      skip2_ff <= buck2_ff[BVR_SKIP_BIT];
    end
  end

  // applied codes: an apply in the same cycle as a write uses the old value
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      code1_ff <= BVR_RST_BUCK1[BVR_CODE_W-1:0];
      code2_ff <= BVR_RST_BUCK2[BVR_CODE_W-1:0];
    end else if (apply) begin
      code1_ff <= buck1_ff[BVR_CODE_W-1:0];
      code2_ff <= buck2_ff[BVR_CODE_W-1:0];
    end
  end

  bvr_blank_timer #(.CYCLES(BLANK_CYCLES)) u_blank1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(wr1),
    .active(blank1)
  );

  bvr_blank_timer #(.CYCLES(BLANK_CYCLES)) u_blank2 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(wr2),
    .active(blank2)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      blank1_ff <= 1'b0;
      blank2_ff <= 1'b0;
    end else begin
      blank1_ff <= blank1 || wr1;
      blank2_ff <= blank2 || wr2;
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        BVR_ADDR_BUCK1: rdata_ff <= buck1_ff & BVR_RMASK;
        BVR_ADDR_BUCK2: rdata_ff <= buck2_ff & BVR_RMASK;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_ff;
  assign buck1_skip_en = skip1_ff;
  assign buck2_skip_en = skip2_ff;
  assign buck1_code_out = code1_ff;
  assign buck2_code_out = code2_ff;
  assign buck1_mon_blank = blank1_ff;
  assign buck2_mon_blank = blank2_ff;
endmodule // bvr_bank
`default_nettype wire

// ==== hw/bvr_pkg.sv ====
// package: register map and timing constants of the buck voltage register bank
package bvr_pkg;
  localparam logic [7:0] BVR_ADDR_BUCK1 = 8'h16;
  localparam logic [7:0] BVR_ADDR_BUCK2 = 8'h17;
  localparam logic [7:0] BVR_ADDR_APPLY = 8'h1A;
  localparam logic [7:0] BVR_RST_BUCK1 = 8'h80;
  localparam logic [7:0] BVR_RST_BUCK2 = 8'h99;
  localparam int BVR_SKIP_BIT = 7;
  localparam int BVR_RSVD_BIT = 6;
  localparam int BVR_CODE_W = 6;
  localparam int BVR_APPLY_BIT = 0;
  localparam int BVR_APPLY_ALT_BIT = 1;
  localparam logic [7:0] BVR_RMASK = 8'hBF;
  localparam int BVR_CLK_HZ = 10000000;
  localparam int BVR_BLANK_MS = 5;
  localparam int BVR_BLANK_CYC = BVR_CLK_HZ / 1000 * BVR_BLANK_MS;
endpackage : bvr_pkg

// ==== hw/bvr_blank_timer.sv ====
// one-shot blanking timer: restarts on each trigger, high while counting
`timescale 1ns/10ps
`default_nettype none
module bvr_blank_timer #(
  parameter int CYCLES = 50000
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  output logic active
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_ff;

  initial begin
    if (CYCLES < 1) $error("bvr_blank_timer: CYCLES must be at least 1");
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (start) begin
      cnt_ff <= W'(CYCLES);
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  assign active = (cnt_ff != '0);
endmodule // bvr_blank_timer
`default_nettype wire

// ==== tb/bvr_bank_properties.sv ====
// checker: port timing of the bank
`timescale 1ns/10ps
`default_nettype none
module bvr_bank_properties #(parameter int BLANK_CYCLES = 20) (
  input wire logic sys_clk, rst_n, reg_wr, reg_rd, unlocked,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic buck1_skip_en, buck2_skip_en, buck1_mon_blank,
  input wire logic buck2_mon_blank,
  input wire logic [5:0] buck1_code_out, buck2_code_out);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire w1 = reg_wr && unlocked && reg_addr == 8'h16;
  wire w2 = reg_wr && unlocked && reg_addr == 8'h17;
  wire ap = reg_wr && reg_addr == 8'h1A;
  // a blank still running from an earlier write would mask the check
  wire lk = reg_wr && !unlocked && !buck1_mon_blank;
  rsvd_zero_a: assert property (reg_rd |=> !reg_rdata[6])
    else $error("rsvd");
  blank_one_a: assert property (w1 |=> buck1_mon_blank[*8])
    else $error("blank1");
  blank_two_a: assert property (w2 |=> buck2_mon_blank[*8])
    else $error("blank2");
  lock_blank_a: assert property (!reg_wr ##1 lk |=> !buck1_mon_blank)
    else $error("locked");
  code_one_a:
    assert property ($changed(buck1_code_out) |-> $past(ap))
    else $error("code1");
  code_two_a:
    assert property ($changed(buck2_code_out) |-> $past(ap))
    else $error("code2");
  skip_one_a:
    assert property (w1 |-> ##2 buck1_skip_en == $past(reg_wdata[7], 2))
    else $error("skip1");
  skip_two_a:
    assert property (w2 |-> ##2 buck2_skip_en == $past(reg_wdata[7], 2))
    else $error("skip2");
endmodule // bvr_bank_properties
bind bvr_bank bvr_bank_properties #(.BLANK_CYCLES(BLANK_CYCLES)) u_p (.*);
`default_nettype wire

// ==== tb/bvr_host.sv ====
// host model: one strobed access per call
`timescale 1ns/10ps
`default_nettype none
module bvr_host (input wire logic sys_clk, output logic reg_wr, reg_rd,
  unlocked, output logic [7:0] reg_addr, reg_wdata);
  initial {reg_wr, reg_rd, unlocked, reg_addr, reg_wdata} = '0;
  task automatic acc(input logic w, u, input logic [7:0] ad, dt);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    unlocked <= u;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
endmodule // bvr_host
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: bank driven by the host model
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 0, rst_n = 0, rd_d = 0, reg_wr, reg_rd, unlocked;
  logic buck1_skip_en, buck2_skip_en, buck1_mon_blank, buck2_mon_blank;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [11:0] q[$];
  logic [5:0] buck1_code_out, buck2_code_out;
  int n_mismatch = 0, comparisons = 0;
  initial forever #50 sys_clk = !sys_clk;
  bvr_host h (.*);
  bvr_bank #(.BLANK_CYCLES(20)) uut (.*);
  task automatic cmp(input logic [11:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t %h", $time, g);
    end
  endtask
  task automatic rdx(input logic [7:0] ad, e);
    q.push_back({4'h0, e});
    h.acc(0, 0, ad, 8'h00);
  endtask
  always @(posedge sys_clk) begin
    if (rd_d) cmp({4'h0, reg_rdata}, q.pop_front());
    rd_d <= reg_rd;
  end
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(29));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1;
    rdx(8'h16, 8'h80);
    rdx(8'h17, 8'h99);
    rdx(8'h1A, 8'h00);
    h.acc(1, 0, 8'h16, 8'h3F);
    rdx(8'h16, 8'h80);
    for (int i = 0; i < 4; i++) begin
      v = i ? 8'($urandom) : 8'hFF;
      h.acc(1, 1, 8'h16, v);
      h.acc(1, 1, 8'h17, ~v);
      rdx(8'h17, ~v & 8'hBF);
      rdx(8'h16, v & 8'hBF);
      h.acc(1, 0, 8'h1A, 8'(1 << i[0]));
      @(posedge sys_clk) #1;
      cmp({buck1_code_out, buck2_code_out}, {v[5:0], ~v[5:0]});
      cmp({8'h0, buck1_skip_en, buck2_skip_en, buck1_mon_blank,
        buck2_mon_blank}, {8'h0, v[7], ~v[7], 2'b11});
    end
    // blanking must lapse once writes stop; bounded so a stuck flag fails
    for (int k = 0; k < 40 && buck2_mon_blank; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (buck2_mon_blank) begin
      n_mismatch++;
      $display("MISMATCH %0t blank timeout", $time);
    end
    cmp({10'h0, buck1_mon_blank, buck2_mon_blank}, 12'h000);
    print_verdict;
  end
endmodule // tb
`default_nettype wire
